/* File: hdl/glcd_pkg.sv */
// glcd_pkg: constants and carrier types of the grayscale column driver with display memory.
// assumes one host clock domain (clk) and one link domain clocked by line_latch_clock.
package glcd_pkg;
    localparam int COLS = 160;
    localparam int ROWS = 240;
    localparam int PIX_PER_BYTE = 4;
    localparam int BYTES_PER_ROW = COLS / PIX_PER_BYTE;
    localparam int ROW_ADDR_LSB = 7;
    localparam int ROW_ADDR_W = 9;
    localparam int BYTE_ADDR_W = 7;
    localparam int FRC_PHASES = 3;

    localparam logic [8:0] ROW_RESET = 9'h000;
    localparam logic [1:0] PHASE_RESET = 2'h0;
    localparam logic [8:0] ROW_LAST = 9'h0EF;
    localparam logic [1:0] PHASE_LAST = 2'h2;
    localparam logic [8:0] ROW_WINDOW = 9'h0F0;
    localparam logic [6:0] BYTE_WINDOW = 7'h28;

    // drive level codes on each column output
    localparam logic [1:0] LVL_SELECT_HIGH = 2'h0;
    localparam logic [1:0] LVL_SELECT_LOW = 2'h1;
    localparam logic [1:0] LVL_DESELECT_HIGH = 2'h2;
    localparam logic [1:0] LVL_DESELECT_LOW = 2'h3;
    localparam logic [1:0] LVL_RESET = LVL_SELECT_HIGH;
    localparam logic [7:0] DATA_RESET = 8'h00;

    typedef struct packed {
        logic cs_n;
        logic we_n;
        logic oe_n;
        logic [15:0] addr;
        logic [7:0] data;
    } glcd_host_t;

    typedef struct packed {
        logic [8:0] row;
        logic [1:0] phase;
    } glcd_line_t;

    typedef struct packed {
        logic hit;
        logic [7:0] row;
        logic [5:0] byte_idx;
    } glcd_dec_t;
endpackage : glcd_pkg

/* File: hdl/glcd_column_driver.sv */
// glcd_column_driver: display memory, host sram port, refresh path and 160 column drivers.
// host pins and straps are asynchronous to clk; the line clock is a clock port of its own.
`timescale 1ns/10ps
module glcd_column_driver
    import glcd_pkg::*;
#(
    parameter int NCOLS = COLS,
    parameter int NROWS = ROWS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic line_latch_clock,
    input wire logic frame_start_marker,
    input wire logic ac_polarity,
    input wire logic display_blank_n,
    input wire logic output_reverse,
    input wire logic chip_id_bit0,
    input wire logic chip_id_bit1,
    input wire logic host_cs_n,
    input wire logic host_we_n,
    input wire logic host_oe_n,
    input wire logic [15:0] host_address,
    input wire logic [7:0] host_data_in,
    output logic [7:0] host_data_out,
    output logic host_data_oe_n,
    output logic [NCOLS-1:0][1:0] column_outputs
);

    if (NCOLS != COLS || NROWS != ROWS) begin : g_size_check
        $error("glcd_column_driver: only the 160 by 240 memory map is served");
    end

    // link domain: scan counter and frame phase
    glcd_line_t line_q;
    logic line_tog_q;

    // row and gray phase share one process since they form one struct;
    // the gray phase steps once per frame, the controller marks frames
    always_ff @(posedge line_latch_clock or posedge rst) begin
        if (rst) begin
            line_q.row <= ROW_RESET;
            line_q.phase <= PHASE_RESET;
        end else if (frame_start_marker) begin
            line_q.row <= ROW_RESET;
            line_q.phase <= (line_q.phase == PHASE_LAST) ? PHASE_RESET
                                                          : line_q.phase + 2'h1;
        end else if (line_q.row == ROW_LAST) begin
            line_q.row <= ROW_RESET;
        end else begin
            line_q.row <= line_q.row + 9'h001;
        end
    end

    always_ff @(posedge line_latch_clock or posedge rst) begin
        if (rst) begin
            line_tog_q <= 1'b0;
        end else begin
            line_tog_q <= ~line_tog_q;
        end
    end

    // clk domain: toggle synchroniser; line_q is stable long before the
    // synchronised toggle is seen since lines are tens of microseconds apart
    logic tog_s1_q;
    logic tog_s2_q;
    logic tog_s3_q;
    logic line_event;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tog_s1_q <= 1'b0;
            tog_s2_q <= 1'b0;
            tog_s3_q <= 1'b0;
        end else begin
            tog_s1_q <= line_tog_q;
            tog_s2_q <= tog_s1_q;
            tog_s3_q <= tog_s2_q;
        end
    end

    assign line_event = tog_s2_q ^ tog_s3_q;

    // pin synchronisers
    glcd_host_t host_pins;
    glcd_host_t host_s1_q;
    glcd_host_t host_s2_q;
    glcd_host_t host_s3_q;
    logic [4:0] strap_s1_q;
    logic [4:0] strap_s2_q;
    logic rev_q;
    logic [1:0] id_q;
    logic pol_q;
    logic blank_n_q;

    assign host_pins = '{cs_n: host_cs_n, we_n: host_we_n, oe_n: host_oe_n,
                         addr: host_address, data: host_data_in};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            host_s1_q <= '{cs_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 16'h0000, data: DATA_RESET};
            host_s2_q <= '{cs_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 16'h0000, data: DATA_RESET};
            host_s3_q <= '{cs_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 16'h0000, data: DATA_RESET};
        end else begin
            host_s1_q <= host_pins;
            host_s2_q <= host_s1_q;
            host_s3_q <= host_s2_q;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strap_s1_q <= 5'h00;
            strap_s2_q <= 5'h00;
        end else begin
            strap_s1_q <= {output_reverse, chip_id_bit1, chip_id_bit0, ac_polarity,
                           display_blank_n};
            strap_s2_q <= strap_s1_q;
        end
    end

    assign rev_q = strap_s2_q[4];
    assign id_q = strap_s2_q[3:2];
    assign pol_q = strap_s2_q[1];
    assign blank_n_q = strap_s2_q[0];

    // window decode: id bit0 picks top/bottom rows when outputs run
    // across the panel, left/right byte ranges when they run down it
    function automatic glcd_dec_t decode(input logic [15:0] addr, input logic [1:0] id,
                                         input logic rev);
        logic [8:0] row_f;
        logic [6:0] byte_f;
        logic [8:0] row_base;
        logic [6:0] byte_base;
        logic [8:0] row_l;
        logic [6:0] byte_l;
        glcd_dec_t d;
        row_f = addr[ROW_ADDR_LSB +: ROW_ADDR_W];
        byte_f = addr[BYTE_ADDR_W-1:0];
        row_base = (rev ? id[1] : id[0]) ? ROW_WINDOW : ROW_RESET;
        byte_base = (rev ? id[0] : id[1]) ? BYTE_WINDOW : 7'h00;
        row_l = row_f - row_base;
        byte_l = byte_f - byte_base;
        d.hit = (row_f >= row_base) && (row_l < ROW_WINDOW)
                && (byte_f >= byte_base) && (byte_l < BYTE_WINDOW);
        d.row = row_l[7:0];
        d.byte_idx = byte_l[5:0];
        return d;
    endfunction : decode

    // display memory: one row of 40 bytes per word, static, no refresh
    logic [BYTES_PER_ROW-1:0][7:0] mem [ROWS];
    glcd_dec_t dec_now;
    glcd_dec_t dec_prev;
    logic write_end;
    logic read_on;

    assign dec_now = decode(host_s2_q.addr, id_q, rev_q);
    assign dec_prev = decode(host_s3_q.addr, id_q, rev_q);

    // a write commits when the strobe rises, with address and data from
    // the last stable sample before the edge, as an sram latches them
    assign write_end = host_s2_q.we_n && !host_s3_q.we_n && !host_s3_q.cs_n
                       && dec_prev.hit;
    assign read_on = !host_s2_q.cs_n && !host_s2_q.oe_n && host_s2_q.we_n && dec_now.hit;

    always_ff @(posedge clk) begin
        if (write_end) begin
            mem[dec_prev.row][dec_prev.byte_idx] <= host_s3_q.data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            host_data_out <= DATA_RESET;
        end else if (read_on) begin
            host_data_out <= mem[dec_now.row][dec_now.byte_idx];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            host_data_oe_n <= 1'b1;
        end else begin
            host_data_oe_n <= ~read_on;
        end
    end

    // refresh: dedicated read port, so host cycles are never stretched or lost
    logic [BYTES_PER_ROW-1:0][7:0] row_word;
    logic [NCOLS-1:0] frc_d;
    logic [NCOLS-1:0] latch1_q;
    logic latch1_vld_q;

    assign row_word = mem[line_q.row[7:0]];

    // pixel k of a byte sits in bits 2k+1:2k; level v lights v of 3 frames
    for (genvar c = 0; c < NCOLS; c++) begin : g_col
        logic [1:0] pix;
        assign pix = row_word[c / PIX_PER_BYTE][2*(c % PIX_PER_BYTE) +: 2];
        assign frc_d[c] = (line_q.phase < pix);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            latch1_q <= '0;
        end else if (line_event) begin
            latch1_q <= frc_d;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            latch1_vld_q <= 1'b0;
        end else begin
            latch1_vld_q <= line_event;
        end
    end

    // blank and polarity act at once; pixel data changes only per line
    logic [NCOLS-1:0] shown_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shown_q <= '0;
        end else if (latch1_vld_q) begin
            shown_q <= latch1_q;
        end
    end

    // one process owns the whole output vector, so it has a single driver
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int c = 0; c < NCOLS; c++) begin
                column_outputs[c] <= LVL_RESET;
            end
        end else begin
            for (int c = 0; c < NCOLS; c++) begin
                if (!blank_n_q) begin
                    column_outputs[c] <= LVL_SELECT_HIGH;
                end else if (shown_q[rev_q ? NCOLS-1-c : c]) begin
                    column_outputs[c] <= pol_q ? LVL_SELECT_LOW : LVL_SELECT_HIGH;
                end else begin
                    column_outputs[c] <= pol_q ? LVL_DESELECT_HIGH : LVL_DESELECT_LOW;
                end
            end
        end
    end
endmodule : glcd_column_driver

/* File: dv/glcd_chk.sv */
// glcd_chk: port assertions for the grayscale column driver.
// assumes it is bound into every driver instance; sees only its ports.
`timescale 1ns/10ps
module glcd_chk
    import glcd_pkg::*;
#(
    parameter int NCOLS = COLS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic line_latch_clock,
    input wire logic display_blank_n,
    input wire logic ac_polarity,
    input wire logic output_reverse,
    input wire logic chip_id_bit0,
    input wire logic chip_id_bit1,
    input wire logic host_cs_n,
    input wire logic host_we_n,
    input wire logic host_oe_n,
    input wire logic [15:0] host_address,
    input wire logic host_data_oe_n,
    input wire logic [NCOLS-1:0][1:0] column_outputs
);
    logic seen_q;
    logic rsel, bsel, hit, all_pos, all_neg;
    logic [9:0] lrow;
    logic [7:0] lbyte;
    // outputs leave their reset code once the synchronised blank strap is high, before any line is shown
    always_ff @(posedge line_latch_clock or posedge rst) begin
        if (rst) seen_q <= 1'b0;
        else seen_q <= 1'b1;
    end
    assign rsel = output_reverse ? chip_id_bit1 : chip_id_bit0;
    assign bsel = output_reverse ? chip_id_bit0 : chip_id_bit1;
    assign lrow = {1'b0, host_address[15:7]} - (rsel ? 10'h0f0 : 10'h000);
    assign lbyte = {1'b0, host_address[6:0]} - (bsel ? 8'h28 : 8'h00);
    assign hit = lrow < 10'h0f0 && lbyte < 8'h28;
    always_comb begin
        all_pos = 1'b1;
        all_neg = 1'b1;
        for (int c = 0; c < NCOLS; c++) begin
            all_pos &= column_outputs[c] inside {2'h1, 2'h2};
            all_neg &= column_outputs[c] inside {2'h0, 2'h3};
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_blank; !display_blank_n [*6] |-> column_outputs == '0; endproperty
    a_blank: assert property (p_blank)
        else $error("outputs not blanked");
    property p_cs_idle; host_cs_n [*5] |-> host_data_oe_n; endproperty
    a_cs_idle: assert property (p_cs_idle)
        else $error("bus driven while deselected");
    property p_write_hiz; !host_we_n [*4] |-> host_data_oe_n; endproperty
    a_write_hiz: assert property (p_write_hiz)
        else $error("bus driven during write");
    property p_oe_idle; host_oe_n [*5] |-> host_data_oe_n; endproperty
    a_oe_idle: assert property (p_oe_idle)
        else $error("bus driven without read strobe");
    property p_read_drive;
        (!host_cs_n && !host_oe_n && host_we_n && hit) [*4] |-> !host_data_oe_n;
    endproperty
    a_read_drive: assert property (p_read_drive)
        else $error("read in window not driven");
    property p_drive_cause;
        !host_data_oe_n |->
            !$past(host_cs_n, 2) || !$past(host_cs_n, 3) || !$past(host_cs_n, 4);
    endproperty
    a_drive_cause: assert property (p_drive_cause)
        else $error("bus driven with no recent select");
    property p_pol_hi; (seen_q && display_blank_n && ac_polarity) [*8] |-> all_pos; endproperty
    a_pol_hi: assert property (p_pol_hi)
        else $error("level outside positive pair");
    property p_pol_lo; (seen_q && display_blank_n && !ac_polarity) [*8] |-> all_neg; endproperty
    a_pol_lo: assert property (p_pol_lo)
        else $error("level outside negative pair");
endmodule : glcd_chk
bind glcd_column_driver glcd_chk #(.NCOLS(NCOLS)) u_chk (.clk, .rst, .line_latch_clock,
    .display_blank_n, .ac_polarity, .output_reverse, .chip_id_bit0, .chip_id_bit1,
    .host_cs_n, .host_we_n, .host_oe_n, .host_address, .host_data_oe_n, .column_outputs);

/* File: dv/glcd_ctrl_model.sv */
// glcd_ctrl_model: timing controller that feeds line pulses, marker and polarity.
// assumes the caller leaves at least 8 clk between lines.
`timescale 1ns/10ps
module glcd_ctrl_model (
    output logic line_latch_clock,
    output logic frame_start_marker,
    output logic ac_polarity
);
    initial begin
        line_latch_clock = 1'b0;
        frame_start_marker = 1'b0;
        ac_polarity = 1'b0;
    end
    // one 7.5 ns high pulse per line; the clock stands low between lines
    task automatic line(input logic first);
        frame_start_marker = first;
        if (first) ac_polarity = ~ac_polarity;
        #20;
        line_latch_clock = 1'b1;
        #7.5;
        line_latch_clock = 1'b0;
        #20;
        frame_start_marker = 1'b0;
    endtask : line
endmodule : glcd_ctrl_model

/* File: dv/glcd_column_driver_tb.sv */
// glcd_column_driver_tb: self-checking bench for the column driver.
// assumes the controller model drives the link pins; host pins move at negedge.
`timescale 1ns/10ps
module glcd_column_driver_tb import glcd_pkg::*;;
    logic clk, rst, line_latch_clock, frame_start_marker, ac_polarity;
    logic display_blank_n, output_reverse, chip_id_bit0, chip_id_bit1;
    logic host_cs_n, host_we_n, host_oe_n, host_data_oe_n;
    logic [15:0] host_address;
    logic [7:0] host_data_in, host_data_out;
    logic [COLS-1:0][1:0] column_outputs;
    int fail_count = 0;
    int n_tests = 0;
    int cyc = 0;
    glcd_column_driver uut (.clk, .rst, .line_latch_clock, .frame_start_marker,
        .ac_polarity, .display_blank_n, .output_reverse, .chip_id_bit0, .chip_id_bit1,
        .host_cs_n, .host_we_n, .host_oe_n, .host_address, .host_data_in,
        .host_data_out, .host_data_oe_n, .column_outputs);
    glcd_ctrl_model m (.line_latch_clock, .frame_start_marker, .ac_polarity);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_sim
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            end_sim();
        end
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask : wait_clk
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        host_cs_n = 1'b0;
        host_address = a;
        host_data_in = d;
        host_we_n = 1'b0;
        wait_clk(4);
        host_we_n = 1'b1;
        wait_clk(2);
        host_cs_n = 1'b1;
        host_data_in = ~d;
        wait_clk(4);
    endtask : wr
    task automatic rdchk(input logic [15:0] a, input logic drive, input logic [7:0] e);
        host_cs_n = 1'b0;
        host_address = a;
        host_oe_n = 1'b0;
        wait_clk(5);
        chk("data_oe_n", {7'h00, ~drive}, {7'h00, host_data_oe_n});
        if (drive) chk("rdata", e, host_data_out);
        host_oe_n = 1'b1;
        host_cs_n = 1'b1;
        wait_clk(5);
    endtask : rdchk
    function automatic logic [7:0] lvl(input logic lit);
        if (lit) return {6'h00, m.ac_polarity ? LVL_SELECT_LOW : LVL_SELECT_HIGH};
        return {6'h00, m.ac_polarity ? LVL_DESELECT_HIGH : LVL_DESELECT_LOW};
    endfunction : lvl
    task automatic ln(input logic first, input int c, input logic lit);
        m.line(first);
        wait_clk(10);
        chk("column", lvl(lit), {6'h00, column_outputs[c]});
    endtask : ln
    task automatic t_mem();
        wr(16'h0000, 8'hc6);
        wr(16'h77a7, 8'h3b);
        rdchk(16'h0000, 1'b1, 8'hc6);
        rdchk(16'h77a7, 1'b1, 8'h3b);
    endtask : t_mem
    task automatic t_window();
        rdchk(16'h0028, 1'b0, 8'h00);
        wr(16'h7800, 8'h11);
        chip_id_bit0 = 1'b1;
        wait_clk(4);
        rdchk(16'h7800, 1'b1, 8'hc6);
        rdchk(16'h0000, 1'b0, 8'h00);
        output_reverse = 1'b1;
        wait_clk(4);
        rdchk(16'h0028, 1'b1, 8'hc6);
        output_reverse = 1'b0;
        chip_id_bit0 = 1'b0;
        wait_clk(4);
    endtask : t_window
    task automatic t_display();
        wr(16'h0000, 8'h03);
        wr(16'h0027, 8'h00);
        wr(16'h0080, 8'h00);
        ln(1'b1, 0, 1'b1);
        chk("column", lvl(1'b0), {6'h00, column_outputs[1]});
        ln(1'b0, 0, 1'b0);
        ln(1'b1, 0, 1'b1);
        output_reverse = 1'b1;
        ln(1'b1, 159, 1'b1);
        chk("column", lvl(1'b0), {6'h00, column_outputs[0]});
        output_reverse = 1'b0;
        wait_clk(4);
    endtask : t_display
    task automatic t_blank();
        display_blank_n = 1'b0;
        wait_clk(6);
        chk("blanked", 8'h01, {7'h00, column_outputs === '0});
        display_blank_n = 1'b1;
        wait_clk(6);
        chk("column", lvl(1'b1), {6'h00, column_outputs[0]});
    endtask : t_blank
    initial begin
        rst = 1'b1;
        display_blank_n = 1'b1;
        output_reverse = 1'b0;
        chip_id_bit0 = 1'b0;
        chip_id_bit1 = 1'b0;
        host_cs_n = 1'b1;
        host_we_n = 1'b1;
        host_oe_n = 1'b1;
        host_address = 16'h0000;
        host_data_in = 8'h00;
        wait_clk(3);
        rst = 1'b0;
        wait_clk(2);
        t_mem();
        t_window();
        t_display();
        t_blank();
        end_sim();
    end
endmodule : glcd_column_driver_tb
